// ===== rtl/eeprom_params.svh
/*
 * Constants of the serial array-fill block: frame lengths, command codes,
 * settle and program timing.
 * Assumes the includer wraps nothing around it; definitions only.
 */
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

`define FRAME_CNT_W     5
`define FRAME_BITS_W    24
`define FRAME_CNT_MAX   5'h1f
`define LEN_CMD_X16     5'h08
`define LEN_CMD_X8      5'h09
`define LEN_FILL_X16    5'h18
`define LEN_FILL_X8     5'h11
`define OP_DISABLE      4'h0
`define OP_FILL_ALL     4'h1
`define OP_ENABLE       4'h3
`define MEM_BYTES       128
`define MEM_ADDR_W      7
`define SETTLE_CYCLES   2'h2
`define CLK_PERIOD_NS   50
`define PROG_TIME_NS    5000000
`define PROG_CYCLES     ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/eeprom_pkg.sv
/*
 * Types shared by the array-fill block.
 * Assumes eeprom_params.svh for the widths.
 */
`include "eeprom_params.svh"

package eeprom_pkg;

    // sequencer of the self-timed program cycle
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_PROG
    } prog_state_t;

    // what the serial-clock side hands over once select drops
    typedef struct packed {
        logic [`FRAME_CNT_W-1:0]  count;
        logic [`FRAME_BITS_W-1:0] bits;
    } link_frame_t;

endpackage

// ===== rtl/bit_sync.sv
/*
 * Two-flop level synchroniser, one lane per bit.
 * Assumes each lane is a slowly changing level from another clock or a pin.
 */
`timescale 1ns/100ps

module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // first stage is read by the second stage only
    always_comb
    begin
        meta_next = d_i;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_reg <= '0;
            q_reg    <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q_o = q_reg;

endmodule

// ===== rtl/eeprom_fill.sv
/*
 * Serial array-fill block: shifts in instructions on the serial clock,
 * decodes program enable/disable and fill-all when select drops, then runs
 * a self-timed fill of the whole array on the system clock and reports
 * ready/busy on the serial output while selected after a fill start.
 * Assumes the host keeps the serial clock still while select is low and
 * holds select low at least a few system clocks after each frame.
 */
`timescale 1ns/100ps
`include "eeprom_params.svh"

module eeprom_fill #(
    parameter int PROG_CYCLES = `PROG_CYCLES
) (
    input  wire logic                   clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   serial_clock_i,
    input  wire logic                   chip_select_i,
    input  wire logic                   serial_data_in_i,
    input  wire logic                   word_width_select_i,
    input  wire logic [`MEM_ADDR_W-1:0] rd_addr_i,
    output logic                        serial_data_out_o,
    output logic                        serial_data_out_oe_o,
    output logic                        busy_o,
    output logic [7:0]                  rd_data_o
);

    localparam int TW = $clog2(PROG_CYCLES + 1);

    // serial-clock domain state
    logic                    hunt_reg;
    logic                    hunt_next;
    logic                    start_tgl_reg;
    logic                    start_tgl_next;
    eeprom_pkg::link_frame_t frame_reg;
    eeprom_pkg::link_frame_t frame_next;
    logic                    link_rst_n;

    // system-clock domain state
    logic [2:0]              sync_q;
    logic                    cs_s;
    logic                    org_s;
    logic                    tgl_s;
    logic                    cs_d_reg;
    logic                    tgl_d_reg;
    eeprom_pkg::prog_state_t state_reg;
    eeprom_pkg::prog_state_t state_next;
    logic [1:0]              settle_reg;
    logic [1:0]              settle_next;
    logic [TW-1:0]           timer_reg;
    logic [TW-1:0]           timer_next;
    logic [`MEM_ADDR_W-1:0]  waddr_reg;
    logic [`MEM_ADDR_W-1:0]  waddr_next;
    logic [15:0]             fill_reg;
    logic [15:0]             fill_next;
    logic                    x16_reg;
    logic                    x16_next;
    logic                    enable_reg;
    logic                    enable_next;
    logic                    show_reg;
    logic                    show_next;
    logic                    fresh_reg;
    logic                    fresh_next;
    logic                    new_frame;
    logic                    do_reg;
    logic                    do_next;
    logic                    oe_reg;
    logic                    oe_next;
    logic                    busy_reg;
    logic                    busy_next;
    logic [7:0]              rdata_reg;
    logic                    mem_we;
    logic [7:0]              mem_wdata;
    logic [7:0]              mem [`MEM_BYTES];

    // decode results of the frozen frame
    logic [4:0]              len_cmd;
    logic [4:0]              len_fill;
    logic [3:0]              cmd_code;
    logic [3:0]              fill_code;
    logic [15:0]             fill_data;
    logic                    is_enable;
    logic                    is_disable;
    logic                    is_fill;

    // hunting restarts whenever select is low; the frame itself is kept
    // so the system side can read it after select has dropped
    assign link_rst_n = arst_n_i & chip_select_i;

    // link side: wait for a start bit, then shift in and count
    always_comb
    begin
        hunt_next      = hunt_reg;
        start_tgl_next = start_tgl_reg;
        frame_next     = frame_reg;
        if (hunt_reg)
        begin
            frame_next.count = '0;
            frame_next.bits  = '0;
            if (serial_data_in_i)
            begin
                hunt_next      = 1'b0;
                start_tgl_next = ~start_tgl_reg;
            end
        end
        else
        begin
            frame_next.bits = {frame_reg.bits[`FRAME_BITS_W-2:0], serial_data_in_i};
            // a count past the frame length marks a late select release
            if (frame_reg.count != `FRAME_CNT_MAX)
            begin
                frame_next.count = frame_reg.count + 5'h01;
            end
        end
    end

    always_ff @(posedge serial_clock_i or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            hunt_reg <= 1'b1;
        end
        else
        begin
            hunt_reg <= hunt_next;
        end
    end

    always_ff @(posedge serial_clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            start_tgl_reg <= 1'b0;
            frame_reg     <= '0;
        end
        else
        begin
            start_tgl_reg <= start_tgl_next;
            frame_reg     <= frame_next;
        end
    end

    // select, width strap and start toggle into the system clock
    bit_sync #(
        .W (3)
    ) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({start_tgl_reg, word_width_select_i, chip_select_i}),
        .q_o      (sync_q)
    );

    assign cs_s  = sync_q[0];
    assign org_s = sync_q[1];
    assign tgl_s = sync_q[2];

    // frame decode; bits are quasi-static once select has been low a while
    always_comb
    begin
        len_cmd    = org_s ? `LEN_CMD_X16 : `LEN_CMD_X8;
        len_fill   = org_s ? `LEN_FILL_X16 : `LEN_FILL_X8;
        cmd_code   = org_s ? frame_reg.bits[7:4] : frame_reg.bits[8:5];
        fill_code  = org_s ? frame_reg.bits[23:20] : frame_reg.bits[16:13];
        fill_data  = org_s ? frame_reg.bits[15:0] : {8'h00, frame_reg.bits[7:0]};
        is_enable  = (frame_reg.count == len_cmd) && (cmd_code == `OP_ENABLE);
        is_disable = (frame_reg.count == len_cmd) && (cmd_code == `OP_DISABLE);
        // exact count only: early or late select release fails here
        is_fill    = (frame_reg.count == len_fill) && (fill_code == `OP_FILL_ALL);
    end

    // sequencer: select fall, settle, then self-timed fill
    always_comb
    begin
        state_next  = state_reg;
        settle_next = settle_reg;
        timer_next  = timer_reg;
        waddr_next  = waddr_reg;
        fill_next   = fill_reg;
        x16_next    = x16_reg;
        enable_next = enable_reg;
        show_next   = show_reg;
        fresh_next  = fresh_reg;
        mem_we      = 1'b0;
        // a select fall consumes its frame, so a bare polling pulse decodes nothing
        new_frame   = (tgl_s != tgl_d_reg);
        if (cs_d_reg && !cs_s)
        begin
            fresh_next = 1'b0;
        end
        // a start bit marks a new frame; a dummy one drops the status only when ready
        if (new_frame)
        begin
            fresh_next = 1'b1;
            if (state_reg != eeprom_pkg::ST_PROG)
            begin
                show_next = 1'b0;
            end
        end
        unique case (state_reg)
            eeprom_pkg::ST_IDLE:
            begin
                if (cs_d_reg && !cs_s && (fresh_reg || new_frame))
                begin
                    state_next  = eeprom_pkg::ST_SETTLE;
                    settle_next = '0;
                end
            end
            eeprom_pkg::ST_SETTLE:
            begin
                // extra wait lets the frozen frame settle past its last edge
                settle_next = settle_reg + 2'h1;
                if (cs_s)
                begin
                    state_next = eeprom_pkg::ST_IDLE;
                end
                else if (settle_reg == `SETTLE_CYCLES)
                begin
                    state_next = eeprom_pkg::ST_IDLE;
                    if (is_enable)
                    begin
                        enable_next = 1'b1;
                    end
                    else if (is_disable)
                    begin
                        enable_next = 1'b0;
                    end
                    else if (is_fill && enable_reg)
                    begin
                        state_next = eeprom_pkg::ST_PROG;
                        timer_next = '0;
                        waddr_next = '0;
                        fill_next  = fill_data;
                        x16_next   = org_s;
                        show_next  = 1'b1;
                    end
                end
            end
            eeprom_pkg::ST_PROG:
            begin
                // runs on the system clock alone; select and frames ignored
                timer_next = timer_reg + TW'(1);
                if (timer_reg < TW'(`MEM_BYTES))
                begin
                    mem_we     = 1'b1;
                    waddr_next = waddr_reg + 7'h01;
                end
                if (timer_reg == TW'(PROG_CYCLES - 1))
                begin
                    state_next = eeprom_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_next = eeprom_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cs_d_reg   <= 1'b0;
            tgl_d_reg  <= 1'b0;
            state_reg  <= eeprom_pkg::ST_IDLE;
            settle_reg <= '0;
            timer_reg  <= '0;
            waddr_reg  <= '0;
            fill_reg   <= 16'h0000;
            x16_reg    <= 1'b0;
            enable_reg <= 1'b0;
            show_reg   <= 1'b0;
            fresh_reg  <= 1'b0;
        end
        else
        begin
            cs_d_reg   <= cs_s;
            tgl_d_reg  <= tgl_s;
            state_reg  <= state_next;
            settle_reg <= settle_next;
            timer_reg  <= timer_next;
            waddr_reg  <= waddr_next;
            fill_reg   <= fill_next;
            x16_reg    <= x16_next;
            enable_reg <= enable_next;
            show_reg   <= show_next;
            fresh_reg  <= fresh_next;
        end
    end

    // even bytes take the high half in word mode; byte mode repeats the byte
    assign mem_wdata = (x16_reg && !waddr_reg[0]) ? fill_reg[15:8] : fill_reg[7:0];

    // plain overwrite, no erase pass needed
    always_ff @(posedge clk_i)
    begin
        if (mem_we)
        begin
            mem[waddr_reg] <= mem_wdata;
        end
        rdata_reg <= mem[rd_addr_i];
    end

    // ready/busy on the serial output while selected after a fill start
    always_comb
    begin
        busy_next = (state_next == eeprom_pkg::ST_PROG);
        oe_next   = cs_s && show_next;
        do_next   = !busy_next;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            do_reg    <= 1'b1;
            oe_reg    <= 1'b0;
            busy_reg  <= 1'b0;
        end
        else
        begin
            do_reg    <= do_next;
            oe_reg    <= oe_next;
            busy_reg  <= busy_next;
        end
    end

    assign serial_data_out_o    = do_reg;
    assign serial_data_out_oe_o = oe_reg;
    assign busy_o               = busy_reg;
    assign rd_data_o            = rdata_reg;

endmodule

// ===== tb/eeprom_fill_props.sv
/* checker for the array-fill block: status level, busy length and gaps.
   assumes it is bound onto eeprom_fill; all checks run on clk_i */
`timescale 1ns/100ps
`include "eeprom_params.svh"
module eeprom_fill_props #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic                   clk_i,
    input wire logic                   arst_n_i,
    input wire logic                   serial_clock_i,
    input wire logic                   chip_select_i,
    input wire logic                   serial_data_in_i,
    input wire logic                   word_width_select_i,
    input wire logic [`MEM_ADDR_W-1:0] rd_addr_i,
    input wire logic                   serial_data_out_o,
    input wire logic                   serial_data_out_oe_o,
    input wire logic                   busy_o,
    input wire logic [7:0]             rd_data_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    int unsigned busy_cnt_reg;
    int unsigned busy_cnt_next;
    // count busy cycles so the length can be judged where busy ends
    always_comb busy_cnt_next = busy_o ? busy_cnt_reg + 1 : 0;
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            busy_cnt_reg <= 0;
        else
            busy_cnt_reg <= busy_cnt_next;
    end
    sequence s_deselected; (!chip_select_i)[*6]; endsequence
    sequence s_busy_hold; busy_o[*8]; endsequence
    property p_busy_len; $fell(busy_o) |-> busy_cnt_reg == PROG_CYCLES; endproperty
    property p_busy_hold; $rose(busy_o) |=> s_busy_hold; endproperty
    property p_idle_gap; $fell(busy_o) |=> (!busy_o)[*8]; endproperty
    property p_busy_low; $rose(busy_o) |-> !serial_data_out_o; endproperty
    property p_ready_high; $fell(busy_o) |-> serial_data_out_o; endproperty
    property p_idle_high; !busy_o && !$past(busy_o) |-> serial_data_out_o; endproperty
    property p_oe_select; s_deselected |-> !serial_data_out_oe_o; endproperty
    property p_reset_out; $rose(arst_n_i) |-> serial_data_out_o && !serial_data_out_oe_o && !busy_o; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    a_idle_gap: assert property (p_idle_gap) else $error("busy restarted too soon");
    a_busy_low: assert property (p_busy_low) else $error("status not busy");
    a_ready_high: assert property (p_ready_high) else $error("status not ready");
    a_idle_high: assert property (p_idle_high) else $error("idle status low");
    a_oe_select: assert property (p_oe_select) else $error("output driven unselected");
    a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong");
endmodule
bind eeprom_fill eeprom_fill_props #(.PROG_CYCLES(PROG_CYCLES)) eeprom_fill_props_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .serial_clock_i(serial_clock_i), .chip_select_i(chip_select_i),
    .serial_data_in_i(serial_data_in_i), .word_width_select_i(word_width_select_i), .rd_addr_i(rd_addr_i),
    .serial_data_out_o(serial_data_out_o), .serial_data_out_oe_o(serial_data_out_oe_o),
    .busy_o(busy_o), .rd_data_o(rd_data_o));

// ===== tb/serial_host.sv
/* host model: shifts frames msb first on its own 15 ns serial clock.
   assumes the bench calls its tasks one at a time */
`timescale 1ns/100ps
module serial_host (
    output logic serial_clock_o,
    output logic chip_select_o,
    output logic serial_data_o
);
    // serial clock stands still outside frames
    initial
    begin
        serial_clock_o = 1'b0;
        chip_select_o = 1'b0;
        serial_data_o = 1'b0;
    end
    // one frame of n bits; a wrong n makes the release early or late
    task automatic send(input logic [31:0] v, input int n);
        chip_select_o = 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data_o = v[i];
            #7.5 serial_clock_o = 1'b1;
            #7.5 serial_clock_o = 1'b0;
        end
        chip_select_o = 1'b0;
        serial_data_o = ~serial_data_o; // no stale bit after release
        #400;
    endtask
    // select without clocks to poll status
    task automatic set_cs(input logic v);
        chip_select_o = v;
    endtask
endmodule

// ===== tb/test_eeprom_fill.sv
/* self-checking bench for the array-fill block with a host model.
   assumes a short program time of 200 clocks */
`timescale 1ns/100ps
module test_eeprom_fill;
    localparam int PROG = 200;
    logic clk_i, arst_n_i, width_sel, sck, cs, sdi, out, oe, busy;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    eeprom_fill #(.PROG_CYCLES(PROG)) eeprom_fill_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .serial_clock_i(sck), .chip_select_i(cs), .serial_data_in_i(sdi), .word_width_select_i(width_sel),
        .rd_addr_i(rd_addr), .serial_data_out_o(out), .serial_data_out_oe_o(oe), .busy_o(busy),
        .rd_data_o(rd_data));
    serial_host serial_host_inst (.serial_clock_o(sck), .chip_select_o(cs), .serial_data_o(sdi));
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic end_sim;
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard, far above the thousand or so cycles needed
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (busy !== lvl && k < lim)
        begin
            tick(1);
            k++;
        end
        chk(busy, lvl);
    endtask
    // walk all bytes; even bytes hold the high half in 16-bit mode
    task automatic mem(input logic [15:0] w, input logic x16);
        for (int a = 0; a < 128; a++)
        begin
            rd_addr = a[6:0];
            tick(1);
            chk(rd_data, (x16 && !a[0]) ? w[15:8] : w[7:0]);
        end
    endtask
    task automatic poll(input logic [1:0] exp);
        serial_host_inst.set_cs(1'b1);
        tick(8);
        chk({oe, out}, exp);
        serial_host_inst.set_cs(1'b0);
        tick(6);
    endtask
    task automatic t_no_enable;
        serial_host_inst.send({9'h110, 16'hA55A}, 25);
        tick(12);
        chk(busy, 1'b0);
        poll(2'b01);
    endtask
    task automatic t_fill16;
        serial_host_inst.send(9'h130, 9);
        serial_host_inst.send({9'h110, 16'hA55A}, 25);
        wait_busy(1'b1, 20);
        poll(2'b10);
        wait_busy(1'b0, PROG + 20);
        poll(2'b11);
        mem(16'hA55A, 1'b1);
        chk(busy, 1'b0);
    endtask
    // release one edge early, then one edge late
    task automatic t_window;
        serial_host_inst.send({9'h110, 16'h0F0F} >> 1, 24);
        tick(12);
        chk(busy, 1'b0);
        serial_host_inst.send({9'h110, 16'h0F0F, 1'b0}, 26);
        tick(12);
        chk(busy, 1'b0);
        mem(16'hA55A, 1'b1);
    endtask
    task automatic t_fill8;
        width_sel = 1'b0;
        tick(4);
        serial_host_inst.send(10'h260, 10);
        serial_host_inst.send({10'h220, 8'h3C}, 18);
        wait_busy(1'b1, 20);
        serial_host_inst.send({10'h220, 8'h77}, 18);
        poll(2'b10);
        wait_busy(1'b0, PROG + 20);
        tick(20);
        chk(busy, 1'b0);
        mem(16'h3C3C, 1'b0);
        serial_host_inst.send(10'h200, 10);
        serial_host_inst.send({10'h220, 8'h55}, 18);
        tick(12);
        chk(busy, 1'b0);
    endtask
    initial
    begin
        arst_n_i = 1'b0;
        width_sel = 1'b1;
        rd_addr = 7'h00;
        repeat (6) @(posedge clk_i);
        #1 arst_n_i = 1'b1;
        tick(4);
        chk({out, oe, busy}, 3'b100);
        t_no_enable;
        t_fill16;
        t_window;
        t_fill8;
        end_sim;
    end
endmodule
